// *** rtl/pcs_pkg.sv ***
package pcs_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam logic [SP_W-1:0] SP_MAX = 5'h1f;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] INTERNAL_SIZE_DEFAULT = 21'h020000;

    // byte offsets of the special function registers, one aligned word each
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h00;
    localparam logic [7:0] ADDR_HIGH_LATCH = 8'h04;
    localparam logic [7:0] ADDR_UPPER_LATCH = 8'h08;
    localparam logic [7:0] ADDR_STACK_POINTER = 8'h0c;
    localparam logic [7:0] ADDR_TOP_LOW = 8'h10;
    localparam logic [7:0] ADDR_TOP_HIGH = 8'h14;
    localparam logic [7:0] ADDR_TOP_UPPER = 8'h18;
    localparam logic [7:0] ADDR_CONFIG = 8'h1c;
    localparam logic [7:0] ADDR_COUNTER_FULL = 8'h20;

    // stack pointer register fields
    localparam int FULL_BIT = 7;
    localparam int UNDERFLOW_BIT = 6;
    // config register fields
    localparam int CFG_BUS_LSB = 0;
    localparam int CFG_SHIFT_BIT = 2;
    localparam int CFG_OVR_BIT = 3;
    localparam logic [1:0] BUS_ONCHIP_ONLY = 2'h3;
    localparam logic [1:0] BUS_RESET = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_STEP = 4'h1,
        OP_CALL = 4'h2,
        OP_GOTO = 4'h3,
        OP_RETURN = 4'h4,
        OP_PUSH = 4'h5,
        OP_POP = 4'h6,
        OP_INT_ACK = 4'h7,
        OP_UNLINK_RET = 4'h8
    } pcs_op_t;

    typedef struct packed {
        pcs_op_t         op;
        logic [PC_W-1:0] target;
    } pcs_cmd_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } pcs_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pcs_axi_rsp_t;
endpackage

// *** rtl/pcs_core.sv ***
// Operation
// - unshifted mode drives raw counter externally
// - shifted mode subtracts on-chip size
// - 21-bit counter in three bytes
// - only low byte directly accessible; the code also reads the whole counter at ADDR_COUNTER_FULL
// - low byte write loads latches
// - low byte read refreshes latches
// - bit zero fixed, step by two
// - calls, gotos load counter directly
// - 31 by 21 stack, 5-bit pointer
// - push on call/interrupt, pop on returns
// - calls and returns keep latches
// - push increments pointer then writes
// - pop reads entry then decrements
// - reset clears pointer, zero is empty
// - top entry registers and pointer accessible
// - full flag after 31 pushes
// - overflow reset stores pc plus two
// - no overflow reset pins pointer 31
// - underflow loads zero, sets flag
// - underflow only redirects to zero
// - push instruction stores current counter
// - pop instruction decrements pointer only
// - flags in bits seven and six
// - bus field 11 means on-chip only
// - shift bit offsets external addresses
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
module pcs_core #(
    parameter logic [pcs_pkg::PC_W-1:0] INTERNAL_SIZE = pcs_pkg::INTERNAL_SIZE_DEFAULT,
    parameter int                       DEPTH         = pcs_pkg::STACK_DEPTH
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      por_n,
    input  wire logic                      step_en,
    input  wire pcs_pkg::pcs_cmd_t         cmd,
    input  wire logic                      unlink_enable,
    input  wire pcs_pkg::pcs_axi_req_t     axi_req,
    output pcs_pkg::pcs_axi_rsp_t          axi_rsp,
    output logic [pcs_pkg::PC_W-1:0]       pc,
    output logic [pcs_pkg::PC_W-1:0]       ext_addr,
    output logic                           ext_select,
    output logic                           overflow_reset
);
    typedef struct packed {
        logic [pcs_pkg::PC_W-1:0] pc_r;
        logic [7:0]               high_latch_r;
        logic [4:0]               upper_latch_r;
        logic [pcs_pkg::SP_W-1:0] sp_r;
        logic                     full_r;
        logic                     unf_r;
        logic [1:0]               bus_cfg_r;
        logic                     shift_r;
        logic                     ovr_en_r;
        logic [pcs_pkg::PC_W-1:0] ext_addr_r;
        logic                     ext_sel_r;
        logic                     ovr_rst_r;
        pcs_pkg::pcs_axi_rsp_t    rsp_r;
    } pcs_state_t;

    pcs_state_t st_r;
    pcs_state_t st_nxt;
    // entry 0 has no storage; index k holds entry k+1
    logic [pcs_pkg::PC_W-1:0] stack_mem [DEPTH];
    logic                     mem_we;
    logic [pcs_pkg::SP_W-1:0] mem_ptr;
    logic [pcs_pkg::PC_W-1:0] mem_wdata;

    function automatic logic [pcs_pkg::PC_W-1:0] align(input logic [pcs_pkg::PC_W-1:0] v);
        align = {v[pcs_pkg::PC_W-1:1], 1'b0};
    endfunction

    logic                     wr_fire;
    logic                     rd_fire;
    logic [pcs_pkg::PC_W-1:0] top_entry;

    assign wr_fire = axi_req.awvalid && axi_req.wvalid && !st_r.rsp_r.bvalid;
    assign rd_fire = axi_req.arvalid && !st_r.rsp_r.rvalid;
    // a process, so a write behind an unchanged pointer is seen at once
    always_comb
    begin
        top_entry = (st_r.sp_r == pcs_pkg::SP_RESET) ? pcs_pkg::PC_RESET : stack_mem[st_r.sp_r - 5'h01];
    end

    always_comb
    begin
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_ptr = st_r.sp_r;
        mem_wdata = st_r.pc_r;
        st_nxt.ovr_rst_r = 1'b0;
        st_nxt.rsp_r.awready = 1'b0;
        st_nxt.rsp_r.wready = 1'b0;
        st_nxt.rsp_r.arready = 1'b0;
        if (st_r.rsp_r.bvalid && axi_req.bready)
        begin
            st_nxt.rsp_r.bvalid = 1'b0;
        end
        if (st_r.rsp_r.rvalid && axi_req.rready)
        begin
            st_nxt.rsp_r.rvalid = 1'b0;
        end

        // sequencer operations; a bus access in the same cycle is applied afterwards but yields to a sequencer stack write or newly set flag
        case (cmd.op)
            pcs_pkg::OP_STEP:
            begin
                if (step_en)
                begin
                    st_nxt.pc_r = st_r.pc_r + pcs_pkg::PC_STEP;
                end
            end
            pcs_pkg::OP_GOTO:
            begin
                st_nxt.pc_r = align(cmd.target);
            end
            // pushes on call, interrupt, push instruction
            pcs_pkg::OP_CALL, pcs_pkg::OP_INT_ACK, pcs_pkg::OP_PUSH:
            begin
                if (cmd.op == pcs_pkg::OP_PUSH)
                begin
                    mem_wdata = st_r.pc_r;
                end
                else
                begin
                    mem_wdata = st_r.pc_r + pcs_pkg::PC_STEP;
                end
                if (st_r.sp_r == pcs_pkg::SP_MAX)
                begin
                    st_nxt.full_r = 1'b1;
                end
                else if (st_r.sp_r == pcs_pkg::SP_MAX - 5'h01)
                begin
                    st_nxt.full_r = 1'b1;
                    mem_we = 1'b1;
                    mem_ptr = pcs_pkg::SP_MAX;
                    if (st_r.ovr_en_r)
                    begin
                        // store pc plus two, reset device
                        mem_wdata = st_r.pc_r + pcs_pkg::PC_STEP;
                        st_nxt.sp_r = pcs_pkg::SP_RESET;
                        st_nxt.pc_r = pcs_pkg::PC_RESET;
                        st_nxt.ovr_rst_r = 1'b1;
                    end
                    else
                    begin
                        st_nxt.sp_r = pcs_pkg::SP_MAX;
                    end
                end
                else
                begin
                    mem_we = 1'b1;
                    mem_ptr = st_r.sp_r + 5'h01;
                    st_nxt.sp_r = st_r.sp_r + 5'h01;
                end
                if (cmd.op == pcs_pkg::OP_CALL && !st_nxt.ovr_rst_r)
                begin
                    // call loads target directly, latches untouched
                    st_nxt.pc_r = align(cmd.target);
                end
                else if (cmd.op == pcs_pkg::OP_INT_ACK && !st_nxt.ovr_rst_r)
                begin
                    st_nxt.pc_r = align(cmd.target);
                end
            end
            pcs_pkg::OP_RETURN, pcs_pkg::OP_UNLINK_RET:
            begin
                // unlink returns pop only when enabled
                if (cmd.op == pcs_pkg::OP_RETURN || unlink_enable)
                begin
                    if (st_r.sp_r == pcs_pkg::SP_RESET)
                    begin
                        // underflow loads zero, nothing else reset
                        st_nxt.pc_r = pcs_pkg::PC_RESET;
                        st_nxt.unf_r = 1'b1;
                    end
                    else
                    begin
                        st_nxt.pc_r = align(top_entry);
                        st_nxt.sp_r = st_r.sp_r - 5'h01;
                    end
                end
            end
            pcs_pkg::OP_POP:
            begin
                if (st_r.sp_r == pcs_pkg::SP_RESET)
                begin
                    st_nxt.unf_r = 1'b1;
                end
                else
                begin
                    st_nxt.sp_r = st_r.sp_r - 5'h01;
                end
            end
            default:
            begin
            end
        endcase

        // write channel: address and data taken together
        if (wr_fire)
        begin
            st_nxt.rsp_r.awready = 1'b1;
            st_nxt.rsp_r.wready = 1'b1;
            st_nxt.rsp_r.bvalid = 1'b1;
            st_nxt.rsp_r.bresp = pcs_pkg::RESP_OKAY;
            if (axi_req.wstrb[0])
            begin
                case (axi_req.awaddr)
                    pcs_pkg::ADDR_COUNTER_LOW:
                    begin
                        // latches join the low byte, bit zero forced
                        st_nxt.pc_r = {st_r.upper_latch_r, st_r.high_latch_r, axi_req.wdata[7:1], 1'b0};
                    end
                    pcs_pkg::ADDR_HIGH_LATCH:
                    begin
                        // high byte reached only via its latch
                        st_nxt.high_latch_r = axi_req.wdata[7:0];
                    end
                    pcs_pkg::ADDR_UPPER_LATCH:
                    begin
                        st_nxt.upper_latch_r = axi_req.wdata[4:0];
                    end
                    pcs_pkg::ADDR_STACK_POINTER:
                    begin
                        // pointer writable, flags cleared by writing zero
                        st_nxt.sp_r = axi_req.wdata[pcs_pkg::SP_W-1:0];
                        st_nxt.full_r = st_nxt.full_r & axi_req.wdata[pcs_pkg::FULL_BIT]
                                        | (st_nxt.full_r & ~st_r.full_r);
                        st_nxt.unf_r = st_nxt.unf_r & axi_req.wdata[pcs_pkg::UNDERFLOW_BIT]
                                       | (st_nxt.unf_r & ~st_r.unf_r);
                    end
                    pcs_pkg::ADDR_TOP_LOW, pcs_pkg::ADDR_TOP_HIGH, pcs_pkg::ADDR_TOP_UPPER:
                    begin
                        // top entry writable; pointer zero has no storage
                        if (st_r.sp_r != pcs_pkg::SP_RESET && !mem_we)
                        begin
                            mem_we = 1'b1;
                            mem_ptr = st_r.sp_r;
                            mem_wdata = top_entry;
                            if (axi_req.awaddr == pcs_pkg::ADDR_TOP_LOW)
                            begin
                                mem_wdata[7:0] = axi_req.wdata[7:0];
                            end
                            else if (axi_req.awaddr == pcs_pkg::ADDR_TOP_HIGH)
                            begin
                                mem_wdata[15:8] = axi_req.wdata[7:0];
                            end
                            else
                            begin
                                mem_wdata[20:16] = axi_req.wdata[4:0];
                            end
                        end
                    end
                    pcs_pkg::ADDR_CONFIG:
                    begin
                        st_nxt.bus_cfg_r = axi_req.wdata[pcs_pkg::CFG_BUS_LSB +: 2];
                        st_nxt.shift_r = axi_req.wdata[pcs_pkg::CFG_SHIFT_BIT];
                        st_nxt.ovr_en_r = axi_req.wdata[pcs_pkg::CFG_OVR_BIT];
                    end
                    pcs_pkg::ADDR_COUNTER_FULL:
                    begin
                    end
                    default:
                    begin
                        st_nxt.rsp_r.bresp = pcs_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end

        if (rd_fire)
        begin
            st_nxt.rsp_r.arready = 1'b1;
            st_nxt.rsp_r.rvalid = 1'b1;
            st_nxt.rsp_r.rresp = pcs_pkg::RESP_OKAY;
            st_nxt.rsp_r.rdata = 32'h00000000;
            case (axi_req.araddr)
                pcs_pkg::ADDR_COUNTER_LOW:
                begin
                    st_nxt.rsp_r.rdata[7:0] = st_r.pc_r[7:0];
                    st_nxt.high_latch_r = st_r.pc_r[15:8];
                    st_nxt.upper_latch_r = st_r.pc_r[20:16];
                end
                pcs_pkg::ADDR_HIGH_LATCH:
                begin
                    st_nxt.rsp_r.rdata[7:0] = st_r.high_latch_r;
                end
                pcs_pkg::ADDR_UPPER_LATCH:
                begin
                    st_nxt.rsp_r.rdata[4:0] = st_r.upper_latch_r;
                end
                pcs_pkg::ADDR_STACK_POINTER:
                begin
                    // full bit 7, underflow bit 6
                    st_nxt.rsp_r.rdata[pcs_pkg::FULL_BIT] = st_r.full_r;
                    st_nxt.rsp_r.rdata[pcs_pkg::UNDERFLOW_BIT] = st_r.unf_r;
                    st_nxt.rsp_r.rdata[pcs_pkg::SP_W-1:0] = st_r.sp_r;
                end
                pcs_pkg::ADDR_TOP_LOW:
                begin
                    st_nxt.rsp_r.rdata[7:0] = top_entry[7:0];
                end
                pcs_pkg::ADDR_TOP_HIGH:
                begin
                    st_nxt.rsp_r.rdata[7:0] = top_entry[15:8];
                end
                pcs_pkg::ADDR_TOP_UPPER:
                begin
                    st_nxt.rsp_r.rdata[4:0] = top_entry[20:16];
                end
                pcs_pkg::ADDR_CONFIG:
                begin
                    st_nxt.rsp_r.rdata[pcs_pkg::CFG_BUS_LSB +: 2] = st_r.bus_cfg_r;
                    st_nxt.rsp_r.rdata[pcs_pkg::CFG_SHIFT_BIT] = st_r.shift_r;
                    st_nxt.rsp_r.rdata[pcs_pkg::CFG_OVR_BIT] = st_r.ovr_en_r;
                end
                pcs_pkg::ADDR_COUNTER_FULL:
                begin
                    st_nxt.rsp_r.rdata[pcs_pkg::PC_W-1:0] = st_r.pc_r;
                end
                default:
                begin
                    st_nxt.rsp_r.rresp = pcs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // field 11 disables the external bus
        st_nxt.ext_sel_r = (st_nxt.bus_cfg_r != pcs_pkg::BUS_ONCHIP_ONLY)
                           && (st_nxt.pc_r >= INTERNAL_SIZE);
        if (st_nxt.shift_r)
        begin
            st_nxt.ext_addr_r = st_nxt.pc_r - INTERNAL_SIZE;
        end
        else
        begin
            st_nxt.ext_addr_r = st_nxt.pc_r;
        end
        if (!st_nxt.ext_sel_r)
        begin
            st_nxt.ext_addr_r = pcs_pkg::PC_RESET;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we && mem_ptr != pcs_pkg::SP_RESET)
        begin
            // entry k stored at index k-1
            stack_mem[mem_ptr - 5'h01] <= mem_wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || st_r.ovr_rst_r)
        begin
            // every reset empties the stack; flags survive unless por_n is low
            st_r <= st_nxt;
            st_r.pc_r <= pcs_pkg::PC_RESET;
            st_r.sp_r <= pcs_pkg::SP_RESET;
            st_r.high_latch_r <= 8'h00;
            st_r.upper_latch_r <= 5'h00;
            st_r.ext_addr_r <= pcs_pkg::PC_RESET;
            st_r.ext_sel_r <= 1'b0;
            st_r.ovr_rst_r <= 1'b0;
            st_r.rsp_r <= '0;
            if (!por_n)
            begin
                st_r.full_r <= 1'b0;
                st_r.unf_r <= 1'b0;
                st_r.bus_cfg_r <= pcs_pkg::BUS_RESET;
                st_r.shift_r <= 1'b0;
                st_r.ovr_en_r <= 1'b1;
            end
            else
            begin
                st_r.full_r <= st_r.full_r | st_nxt.full_r;
                st_r.unf_r <= st_r.unf_r;
                st_r.bus_cfg_r <= st_r.bus_cfg_r;
                st_r.shift_r <= st_r.shift_r;
                st_r.ovr_en_r <= st_r.ovr_en_r;
            end
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp = st_r.rsp_r;
    assign pc = st_r.pc_r;
    assign ext_addr = st_r.ext_addr_r;
    assign ext_select = st_r.ext_sel_r;
    assign overflow_reset = st_r.ovr_rst_r;
endmodule // pcs_core

// *** tb/pcs_core_props.sv ***
module pcs_core_props #(
    parameter logic [pcs_pkg::PC_W-1:0] INTERNAL_SIZE = pcs_pkg::INTERNAL_SIZE_DEFAULT,
    parameter int                       DEPTH         = pcs_pkg::STACK_DEPTH
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  por_n,
    input wire logic                  step_en,
    input wire pcs_pkg::pcs_cmd_t     cmd,
    input wire logic                  unlink_enable,
    input wire pcs_pkg::pcs_axi_req_t axi_req,
    input wire pcs_pkg::pcs_axi_rsp_t axi_rsp,
    input wire logic [20:0]           pc,
    input wire logic [20:0]           ext_addr,
    input wire logic                  ext_select,
    input wire logic                  overflow_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    pc_even_a: assert property (pc[0] == 1'h0)
        else $error("counter bit zero set");
    // a bus write or overflow reset may override the sequencer
    step_adv_a: assert property (cmd.op == pcs_pkg::OP_STEP && step_en && !axi_req.awvalid
        && !overflow_reset |=> pc == $past(pc) + pcs_pkg::PC_STEP)
        else $error("step did not add two");
    jump_load_a: assert property ((cmd.op == pcs_pkg::OP_GOTO || cmd.op == pcs_pkg::OP_CALL)
        && !axi_req.awvalid && !overflow_reset |=> pc == ($past(cmd.target) & ~21'h1))
        else $error("jump target not loaded");
    ovr_pulse_a: assert property (overflow_reset |-> pc == pcs_pkg::PC_RESET ##1 !overflow_reset)
        else $error("overflow reset pulse wrong");
    ext_map_a: assert property (ext_select |-> ext_addr == pc || ext_addr == pc - INTERNAL_SIZE)
        else $error("external address not mapped");
    ext_range_a: assert property (ext_select |-> pc >= INTERNAL_SIZE)
        else $error("external select below on-chip top");
    ext_idle_a: assert property (!ext_select |-> ext_addr == '0)
        else $error("idle external address not zero");
    rst_init_a: assert property ($rose(rst_n) |-> pc == pcs_pkg::PC_RESET && !ext_select)
        else $error("state not cleared by reset");
    wr_ack_a: assert property (axi_req.awvalid && axi_req.wvalid && !axi_rsp.bvalid
        |=> axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
        else $error("write not answered");
    rd_ack_a: assert property (axi_req.arvalid && !axi_rsp.rvalid |=> axi_rsp.rvalid && axi_rsp.arready)
        else $error("read not answered");

    cover property (overflow_reset);
    cover property (ext_select && ext_addr != pc);
    cover property (axi_rsp.rvalid && axi_rsp.rresp == pcs_pkg::RESP_SLVERR);
endmodule // pcs_core_props

bind pcs_core pcs_core_props #(
    .INTERNAL_SIZE(INTERNAL_SIZE),
    .DEPTH        (DEPTH)
) pcs_core_props_inst (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .por_n         (por_n),
    .step_en       (step_en),
    .cmd           (cmd),
    .unlink_enable (unlink_enable),
    .axi_req       (axi_req),
    .axi_rsp       (axi_rsp),
    .pc            (pc),
    .ext_addr      (ext_addr),
    .ext_select    (ext_select),
    .overflow_reset(overflow_reset)
);

// *** tb/pcs_seq_model.sv ***
module pcs_seq_model (
    input wire logic          core_clk,
    output pcs_pkg::pcs_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd = '0;
    // holds one op for n edges, then idles
    task automatic issue(input pcs_pkg::pcs_op_t o, input logic [20:0] t, input int n);
        @(posedge core_clk);
        cmd <= '{op: o, target: t};
        repeat (n) @(posedge core_clk);
        cmd <= '0;
    endtask
endmodule // pcs_seq_model

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  core_clk;
    logic                  rst_n;
    logic                  por_n;
    logic                  step_en;
    logic                  unlink_enable;
    pcs_pkg::pcs_cmd_t     cmd;
    pcs_pkg::pcs_axi_req_t axi_req;
    pcs_pkg::pcs_axi_rsp_t axi_rsp;
    logic [20:0]           pc;
    logic [20:0]           ext_addr;
    logic                  ext_select;
    logic                  overflow_reset;
    logic [31:0]           rdat;
    logic [1:0]            rrsp;
    int                    mismatches;
    int                    num_checks;

    always #5 core_clk = ~core_clk;

    pcs_seq_model pcs_seq_model_inst (
        .core_clk(core_clk),
        .cmd     (cmd)
    );
    pcs_core pcs_core_inst (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .por_n         (por_n),
        .step_en       (step_en),
        .cmd           (cmd),
        .unlink_enable (unlink_enable),
        .axi_req       (axi_req),
        .axi_rsp       (axi_rsp),
        .pc            (pc),
        .ext_addr      (ext_addr),
        .ext_select    (ext_select),
        .overflow_reset(overflow_reset)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic pcchk(input logic [20:0] e);
        chk("pc", {11'h0, e}, {11'h0, pc});
    endtask

    // bounded wait for the write or read answer
    task automatic await(input logic w);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if ((w ? axi_rsp.bvalid : axi_rsp.rvalid) === 1'h1)
            begin
                return;
            end
        end
        mismatches++;
        complete_run();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'h1;
        axi_req.wvalid <= 1'h1;
        axi_req.bready <= 1'h1;
        await(1'h1);
        rrsp = axi_rsp.bresp;
        axi_req.awvalid <= 1'h0;
        axi_req.wvalid <= 1'h0;
        axi_req.bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'h1;
        axi_req.rready <= 1'h1;
        await(1'h0);
        rdat = axi_rsp.rdata;
        rrsp = axi_rsp.rresp;
        axi_req.arvalid <= 1'h0;
        axi_req.rready <= 1'h0;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, e, rdat);
    endtask

    task automatic op(input pcs_pkg::pcs_op_t o, input logic [20:0] t, input int n);
        pcs_seq_model_inst.issue(o, t, n);
        @(negedge core_clk);
    endtask

    task automatic sc_latch();
        wr(pcs_pkg::ADDR_HIGH_LATCH, 32'h12);
        wr(pcs_pkg::ADDR_UPPER_LATCH, 32'h01);
        wr(pcs_pkg::ADDR_COUNTER_LOW, 32'h35);
        rdchk("pc_full", pcs_pkg::ADDR_COUNTER_FULL, 32'h011234);
        op(pcs_pkg::OP_STEP, 21'h0, 1);
        pcchk(21'h011236);
        @(posedge core_clk);
        step_en <= 1'h0;
        op(pcs_pkg::OP_STEP, 21'h0, 1);
        pcchk(21'h011236);
        @(posedge core_clk);
        step_en <= 1'h1;
        op(pcs_pkg::OP_GOTO, 21'h0abcd6, 1);
        rdchk("latch_h", pcs_pkg::ADDR_HIGH_LATCH, 32'h12);
        rdchk("low", pcs_pkg::ADDR_COUNTER_LOW, 32'hd6);
        rdchk("latch_h", pcs_pkg::ADDR_HIGH_LATCH, 32'hbc);
        rdchk("latch_u", pcs_pkg::ADDR_UPPER_LATCH, 32'h0a);
    endtask

    task automatic sc_call();
        wr(pcs_pkg::ADDR_HIGH_LATCH, 32'h77);
        op(pcs_pkg::OP_CALL, 21'h000200, 1);
        rdchk("sp", pcs_pkg::ADDR_STACK_POINTER, 32'h01);
        rdchk("top_l", pcs_pkg::ADDR_TOP_LOW, 32'hd8);
        rdchk("top_u", pcs_pkg::ADDR_TOP_UPPER, 32'h0a);
        wr(pcs_pkg::ADDR_TOP_LOW, 32'h40);
        op(pcs_pkg::OP_INT_ACK, 21'h000008, 1);
        op(pcs_pkg::OP_UNLINK_RET, 21'h0, 1);
        pcchk(21'h000008);
        @(posedge core_clk);
        unlink_enable <= 1'h1;
        op(pcs_pkg::OP_UNLINK_RET, 21'h0, 1);
        pcchk(21'h000202);
        op(pcs_pkg::OP_RETURN, 21'h0, 1);
        pcchk(21'h0abc40);
        rdchk("latch_h", pcs_pkg::ADDR_HIGH_LATCH, 32'h77);
    endtask

    task automatic sc_under();
        op(pcs_pkg::OP_RETURN, 21'h0, 1);
        pcchk(21'h0);
        rdchk("sp", pcs_pkg::ADDR_STACK_POINTER, 32'h40);
        rdchk("cfg", pcs_pkg::ADDR_CONFIG, 32'h0b);
        wr(pcs_pkg::ADDR_STACK_POINTER, 32'h0);
        rdchk("sp", pcs_pkg::ADDR_STACK_POINTER, 32'h0);
        op(pcs_pkg::OP_GOTO, 21'h000100, 1);
        op(pcs_pkg::OP_PUSH, 21'h0, 1);
        op(pcs_pkg::OP_GOTO, 21'h000200, 1);
        op(pcs_pkg::OP_PUSH, 21'h0, 1);
        op(pcs_pkg::OP_POP, 21'h0, 1);
        pcchk(21'h000200);
        rdchk("top_h", pcs_pkg::ADDR_TOP_HIGH, 32'h01);
    endtask

    task automatic sc_ext();
        wr(pcs_pkg::ADDR_CONFIG, 32'h08);
        op(pcs_pkg::OP_GOTO, 21'h020010, 1);
        chk("ext", 32'h020010, {11'h0, ext_addr});
        wr(pcs_pkg::ADDR_CONFIG, 32'h0c);
        op(pcs_pkg::OP_NONE, 21'h0, 1);
        chk("ext", 32'h10, {11'h0, ext_addr});
        wr(pcs_pkg::ADDR_CONFIG, 32'h0f);
        op(pcs_pkg::OP_NONE, 21'h0, 1);
        chk("sel", 32'h0, {31'h0, ext_select});
        rd(8'h24);
        chk("resp", {30'h0, pcs_pkg::RESP_SLVERR}, {30'h0, rrsp});
        wr(8'h24, 32'h0);
        chk("bresp", {30'h0, pcs_pkg::RESP_SLVERR}, {30'h0, rrsp});
    endtask

    task automatic sc_over();
        wr(pcs_pkg::ADDR_STACK_POINTER, 32'h0);
        op(pcs_pkg::OP_PUSH, 21'h0, 31);
        chk("ovr", 32'h1, {31'h0, overflow_reset});
        rdchk("sp", pcs_pkg::ADDR_STACK_POINTER, 32'h80);
        wr(pcs_pkg::ADDR_CONFIG, 32'h03);
        wr(pcs_pkg::ADDR_STACK_POINTER, 32'h0);
        op(pcs_pkg::OP_GOTO, 21'h000456, 1);
        op(pcs_pkg::OP_PUSH, 21'h0, 31);
        rdchk("sp", pcs_pkg::ADDR_STACK_POINTER, 32'h9f);
        op(pcs_pkg::OP_GOTO, 21'h000888, 1);
        op(pcs_pkg::OP_PUSH, 21'h0, 1);
        rdchk("top_l", pcs_pkg::ADDR_TOP_LOW, 32'h56);
    endtask

    initial
    begin
        core_clk = 1'h0;
        rst_n = 1'h0;
        por_n = 1'h0;
        step_en = 1'h1;
        unlink_enable = 1'h0;
        axi_req = '0;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        por_n <= 1'h1;
        sc_latch();
        sc_call();
        sc_under();
        sc_ext();
        sc_over();
        complete_run();
    end
endmodule // testbench
